// *** rtl/edc_check_gen.sv ***
`timescale 1ns/100ps
module edc_check_gen
    import edc_pkg::*;
(
    input  wire logic [DATA_W-1:0]  data,
    output logic      [CHECK_W-1:0] check
);
    always_comb begin
        for (int i = 0; i < CHECK_W; i++) begin
            check[i] = ^(data & MATRIX[i]);
        end
    end
endmodule : edc_check_gen

// *** rtl/edc_host.sv ***
`timescale 1ns/100ps
module edc_host
    import edc_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire logic               cpu_write,
    input  wire logic               cpu_read,
    input  wire logic [DATA_W-1:0]  cpu_wdata,
    input  wire logic [DATA_W-1:0]  arr_data,
    input  wire logic [CHECK_W-1:0] arr_check,
    output logic      [DATA_W-1:0]  cpu_rdata,
    output logic                    cpu_rvalid,
    output logic                    cpu_busy,
    output logic                    uncorrectable,
    output logic                    arr_we,
    output logic      [DATA_W-1:0]  arr_wdata,
    output logic      [CHECK_W-1:0] arr_wcheck,
    edc_if.host                     bus
);
    typedef enum logic [2:0] {
        EDC_IDLE, EDC_RD_WAIT, EDC_CW, EDC_CW_WAIT, EDC_CR, EDC_CR_WAIT,
        EDC_FIX, EDC_FIX_WAIT
    } edc_state_t;

    edc_state_t        state;
    edc_state_t        next_state;
    logic [DATA_W-1:0] hold;
    logic [DATA_W-1:0] next_hold;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic              rvalid;
    logic              next_rvalid;
    logic              unc;
    logic              next_unc;
    logic              dbl;

    assign dbl = {bus.any_error_flag, bus.error_type_flag_high,
                  bus.error_type_flag_low} == EDC_FLAG_DOUBLE;

    always_comb begin
        next_state  = state;
        next_hold   = hold;
        next_rdata  = rdata;
        next_rvalid = 1'b0;
        next_unc    = unc;
        bus.write_req = 1'b0;
        bus.read_req  = 1'b0;
        bus.mode      = EDC_NORMAL;
        bus.sys_data  = cpu_wdata;
        for (int y = 0; y < BYTES; y++) begin
            bus.sys_parity[y] = ^cpu_wdata[y*8 +: 8];
        end
        unique case (state)
            EDC_IDLE: begin
                if (cpu_write) begin
                    bus.write_req = 1'b1;
                end else if (cpu_read) begin
                    bus.read_req = 1'b1;
                    next_state = EDC_RD_WAIT;
                end
            end
            EDC_RD_WAIT: begin
                // wait for analysis before handing data back
                if (bus.rd_valid) begin
                    if (dbl) begin
                        next_state = EDC_CW;
                    end else begin
                        next_rdata  = bus.rd_data;
                        next_rvalid = 1'b1;
                        next_unc    = 1'b0;
                        next_hold   = bus.rd_data;
                        // rewrite any location found in error
                        next_state = bus.any_error_flag ? EDC_FIX
                                                        : EDC_IDLE;
                    end
                end
            end
            EDC_CW: begin
                bus.mode = EDC_COMP_WRITE;
                bus.write_req = 1'b1;
                next_state = EDC_CW_WAIT;
            end
            EDC_CW_WAIT: begin
                if (bus.wr_valid) next_state = EDC_CR;
            end
            EDC_CR: begin
                bus.mode = EDC_COMP_READ;
                bus.read_req = 1'b1;
                next_state = EDC_CR_WAIT;
            end
            EDC_CR_WAIT: begin
                bus.mode = EDC_COMP_READ;
                if (bus.rd_valid) begin
                    next_rdata  = bus.rd_data;
                    next_rvalid = 1'b1;
                    next_unc    = dbl;
                    next_hold   = bus.rd_data;
                    next_state  = EDC_FIX;
                end
            end
            EDC_FIX: begin
                bus.sys_data = hold;
                for (int y = 0; y < BYTES; y++) begin
                    bus.sys_parity[y] = ^hold[y*8 +: 8];
                end
                bus.write_req = 1'b1;
                next_state = EDC_FIX_WAIT;
            end
            EDC_FIX_WAIT: begin
                if (bus.wr_valid) next_state = EDC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state  <= EDC_IDLE;
            hold   <= '0;
            rdata  <= '0;
            rvalid <= 1'b0;
            unc    <= 1'b0;
        end else begin
            state  <= next_state;
            hold   <= next_hold;
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
            unc    <= next_unc;
        end
    end

    assign bus.mem_data  = arr_data;
    assign bus.mem_check = arr_check;
    assign cpu_rdata     = rdata;
    assign cpu_rvalid    = rvalid;
    assign cpu_busy      = (state != EDC_IDLE);
    assign uncorrectable = unc;
    assign arr_we        = bus.wr_valid;
    assign arr_wdata     = bus.wr_data;
    assign arr_wcheck    = bus.wr_check;
endmodule : edc_host

// *** rtl/edc_if.sv ***
`timescale 1ns/100ps
interface edc_if
    import edc_pkg::*;
();
    logic [DATA_W-1:0]  sys_data;
    logic [BYTES-1:0]   sys_parity;
    logic               write_req;
    logic               read_req;
    edc_mode_t          mode;
    logic [DATA_W-1:0]  mem_data;
    logic [CHECK_W-1:0] mem_check;
    logic [DATA_W-1:0]  wr_data;
    logic [CHECK_W-1:0] wr_check;
    logic               wr_valid;
    logic [DATA_W-1:0]  rd_data;
    logic [BYTES-1:0]   rd_parity;
    logic               any_error_flag;
    logic               error_type_flag_high;
    logic               error_type_flag_low;
    logic               parity_error;
    logic               rd_valid;
    modport device (
        input  sys_data, sys_parity, write_req, read_req, mode,
               mem_data, mem_check,
        output wr_data, wr_check, wr_valid, rd_data, rd_parity,
               any_error_flag, error_type_flag_high, error_type_flag_low,
               parity_error, rd_valid
    );
    modport host (
        output sys_data, sys_parity, write_req, read_req, mode,
               mem_data, mem_check,
        input  wr_data, wr_check, wr_valid, rd_data, rd_parity,
               any_error_flag, error_type_flag_high, error_type_flag_low,
               parity_error, rd_valid
    );
endinterface : edc_if

// *** rtl/edc_pkg.sv ***
package edc_pkg;
    localparam int DATA_W  = 16;
    localparam int CHECK_W = 6;
    localparam int BYTES   = DATA_W / 8;
    // check-bit matrix: row i selects the data bits that feed check bit i
    localparam logic [DATA_W-1:0] MATRIX [CHECK_W] = '{
        16'h2CB7, 16'h555B, 16'h9A6D, 16'hE38E, 16'h03F0, 16'hFC00
    };
    typedef enum logic [1:0] {
        EDC_NORMAL, EDC_COMP_WRITE, EDC_COMP_READ
    } edc_mode_t;
    typedef enum logic [2:0] {
        EDC_FLAG_NONE   = 3'h0,
        EDC_FLAG_DOUBLE = 3'h4,
        EDC_FLAG_CHECK  = 3'h6,
        EDC_FLAG_DATA   = 3'h7
    } edc_flag_t;
endpackage : edc_pkg

// *** rtl/edc_slice.sv ***
`timescale 1ns/100ps
// Contract
// - write check bits are parity of data subsets
// - check bits stored beside data word
// - optional byte parity check on writes
// - read regenerates check bits, same matrix
// - syndrome is regenerated xor stored check
// - nonzero syndrome means data or check error
// - flags 000 none 110 check 111 data 100 double
// - byte parity generated toward processor on read
// - monitoring: processor interrupts, extends for correction; host has only the always-correct flow
// - always-correct: processor waits for analysis
// - single data error corrected before return
// - double error: system selects complement write
// - complement write inverts last read word
// - complement read inverts then corrects
// - system rewrites corrected data afterwards
// - full flags after complement read
// - sixteen-bit slice, wider words by more slices
// - system should rewrite errors and scrub; host rewrites errors found on reads, never scrubs
// - six check bits give sec-ded
module edc_slice
    import edc_pkg::*;
#(
    parameter int WIDTH = DATA_W
)(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic parity_check_en,
    edc_if.device     bus
);
    if (WIDTH != DATA_W) begin : g_width_check
        $error("edc_slice serves 16-bit slices only");
    end

    logic [DATA_W-1:0]  last_data;
    logic [CHECK_W-1:0] last_check;
    logic [DATA_W-1:0]  next_last_data;
    logic [CHECK_W-1:0] next_last_check;
    logic [DATA_W-1:0]  next_wr_data;
    logic [CHECK_W-1:0] next_wr_check;
    logic               next_wr_valid;
    logic [DATA_W-1:0]  next_rd_data;
    logic [BYTES-1:0]   next_rd_parity;
    logic [2:0]         next_flags;
    logic               next_parity_error;
    logic               next_rd_valid;
    logic [DATA_W-1:0]  wr_data;
    logic [CHECK_W-1:0] wr_check;
    logic               wr_valid;
    logic [DATA_W-1:0]  rd_data;
    logic [BYTES-1:0]   rd_parity;
    logic [2:0]         flags;
    logic               parity_error;
    logic               rd_valid;

    logic [DATA_W-1:0]  gen_in;
    logic [CHECK_W-1:0] gen_check;
    logic [DATA_W-1:0]  rd_word;
    logic [CHECK_W-1:0] rd_chk;
    logic [CHECK_W-1:0] syndrome;
    logic [DATA_W-1:0]  flip;
    logic               check_hit;
    logic [CHECK_W-1:0] col;

    edc_check_gen u_gen (
        .data  (gen_in),
        .check (gen_check)
    );

    always_comb begin
        // complement read works on the inverted memory word
        rd_word = (bus.mode == EDC_COMP_READ) ? ~bus.mem_data
                                              : bus.mem_data;
        rd_chk  = (bus.mode == EDC_COMP_READ) ? ~bus.mem_check
                                              : bus.mem_check;
        gen_in  = bus.read_req ? rd_word : bus.sys_data;
        syndrome = gen_check ^ rd_chk;
        flip = '0;
        check_hit = 1'b0;
        col = '0;
        for (int b = 0; b < DATA_W; b++) begin
            col = '0;
            for (int i = 0; i < CHECK_W; i++) col[i] = MATRIX[i][b];
            if (syndrome == col) flip[b] = 1'b1;
        end
        for (int i = 0; i < CHECK_W; i++) begin
            if (syndrome == CHECK_W'(1 << i)) check_hit = 1'b1;
        end
    end

    always_comb begin
        next_last_data    = last_data;
        next_last_check   = last_check;
        next_wr_data      = wr_data;
        next_wr_check     = wr_check;
        next_wr_valid     = 1'b0;
        next_rd_data      = rd_data;
        next_rd_parity    = rd_parity;
        next_flags        = flags;
        next_parity_error = parity_error;
        next_rd_valid     = 1'b0;
        if (bus.write_req) begin
            next_wr_valid = 1'b1;
            if (bus.mode == EDC_COMP_WRITE) begin
                next_wr_data  = ~last_data;
                next_wr_check = ~last_check;
            end else begin
                next_wr_data  = bus.sys_data;
                next_wr_check = gen_check;
                next_parity_error = 1'b0;
                for (int y = 0; y < BYTES; y++) begin
                    if (parity_check_en &&
                        (^bus.sys_data[y*8 +: 8]) != bus.sys_parity[y])
                        next_parity_error = 1'b1;
                end
            end
        end else if (bus.read_req) begin
            next_rd_valid   = 1'b1;
            next_last_data  = bus.mem_data;
            next_last_check = bus.mem_check;
            next_rd_data    = rd_word ^ flip;
            for (int y = 0; y < BYTES; y++) begin
                next_rd_parity[y] = ^next_rd_data[y*8 +: 8];
            end
            if (syndrome == '0)
                next_flags = EDC_FLAG_NONE;
            else if (flip != '0)
                next_flags = EDC_FLAG_DATA;
            else if (check_hit)
                next_flags = EDC_FLAG_CHECK;
            else
                next_flags = EDC_FLAG_DOUBLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            last_data    <= '0;
            last_check   <= '0;
            wr_data      <= '0;
            wr_check     <= '0;
            wr_valid     <= 1'b0;
            rd_data      <= '0;
            rd_parity    <= '0;
            flags        <= EDC_FLAG_NONE;
            parity_error <= 1'b0;
            rd_valid     <= 1'b0;
        end else begin
            last_data    <= next_last_data;
            last_check   <= next_last_check;
            wr_data      <= next_wr_data;
            wr_check     <= next_wr_check;
            wr_valid     <= next_wr_valid;
            rd_data      <= next_rd_data;
            rd_parity    <= next_rd_parity;
            flags        <= next_flags;
            parity_error <= next_parity_error;
            rd_valid     <= next_rd_valid;
        end
    end

    assign bus.wr_data              = wr_data;
    assign bus.wr_check             = wr_check;
    assign bus.wr_valid             = wr_valid;
    assign bus.rd_data              = rd_data;
    assign bus.rd_parity            = rd_parity;
    assign bus.any_error_flag       = flags[2];
    assign bus.error_type_flag_high = flags[1];
    assign bus.error_type_flag_low  = flags[0];
    assign bus.parity_error         = parity_error;
    assign bus.rd_valid             = rd_valid;
endmodule : edc_slice

// *** sim/edc_asserts.sv ***
`timescale 1ns/100ps
module edc_asserts
    import edc_pkg::*;
(
    input wire logic               mclk,
    input wire logic               reset,
    input wire logic               write_req,
    input wire logic               read_req,
    input wire edc_mode_t          mode,
    input wire logic [DATA_W-1:0]  sys_data,
    input wire logic [DATA_W-1:0]  mem_data,
    input wire logic [CHECK_W-1:0] mem_check,
    input wire logic [DATA_W-1:0]  wr_data,
    input wire logic [CHECK_W-1:0] wr_check,
    input wire logic               wr_valid,
    input wire logic [DATA_W-1:0]  rd_data,
    input wire logic [BYTES-1:0]   rd_parity,
    input wire logic               rd_valid,
    input wire logic               any_error_flag,
    input wire logic               error_type_flag_high,
    input wire logic               error_type_flag_low
);
    logic [DATA_W-1:0]  last_data;
    logic [CHECK_W-1:0] last_check;
    logic [DATA_W-1:0]  next_last_data;
    logic [CHECK_W-1:0] next_last_check;
    logic [2:0]         flags;
    logic [CHECK_W-1:0] syn;
    logic               rd_take;
    logic [DATA_W-1:0]  in_data;
    logic [CHECK_W-1:0] in_check;
    logic [CHECK_W-1:0] in_syn;
    logic [DATA_W-1:0]  exp_fix;
    logic               col_hit;

    function automatic logic [CHECK_W-1:0] gen(logic [DATA_W-1:0] d);
        logic [CHECK_W-1:0] c;
        for (int i = 0; i < CHECK_W; i++) c[i] = ^(d & MATRIX[i]);
        return c;
    endfunction : gen

    // flip the data bit whose matrix column equals the syndrome
    function automatic logic [DATA_W-1:0] fix(logic [DATA_W-1:0] d,
                                              logic [CHECK_W-1:0] s);
        logic [DATA_W-1:0] r;
        r = d;
        for (int b = 0; b < DATA_W; b++) begin
            if (s == gen(DATA_W'(1) << b)) r[b] = ~d[b];
        end
        return r;
    endfunction : fix

    assign flags    = {any_error_flag, error_type_flag_high,
                       error_type_flag_low};
    assign rd_take  = read_req && !write_req;
    assign syn      = gen(mem_data) ^ mem_check;
    // complement read checks the inverted memory word
    assign in_data  = (mode == EDC_COMP_READ) ? ~mem_data : mem_data;
    assign in_check = (mode == EDC_COMP_READ) ? ~mem_check : mem_check;
    assign in_syn   = gen(in_data) ^ in_check;
    assign exp_fix  = fix(in_data, in_syn);
    assign col_hit  = (exp_fix != in_data);
    // raw word of the latest read, source of a complement write
    always_comb begin
        next_last_data  = rd_take ? mem_data : last_data;
        next_last_check = rd_take ? mem_check : last_check;
    end
    always_ff @(posedge mclk) begin
        last_data  <= reset ? '0 : next_last_data;
        last_check <= reset ? '0 : next_last_check;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    write_ack_a: assert property (write_req |=> wr_valid)
        else $error("write answer missing");
    read_ack_a: assert property (rd_take |=> rd_valid && !wr_valid)
        else $error("read answer missing");
    wr_check_a: assert property (write_req && mode == EDC_NORMAL |=>
        wr_data == $past(sys_data) && wr_check == gen($past(sys_data)))
        else $error("write check bits wrong");
    comp_write_a: assert property (
        write_req && mode == EDC_COMP_WRITE |=>
        wr_data == ~$past(last_data) && wr_check == ~$past(last_check))
        else $error("complement write word wrong");
    rd_parity_a: assert property (rd_valid |->
        rd_parity == {^rd_data[15:8], ^rd_data[7:0]})
        else $error("read byte parity wrong");
    flag_code_a: assert property (rd_valid |->
        flags inside {3'h0, 3'h4, 3'h6, 3'h7})
        else $error("invalid flag code");
    clean_read_a: assert property (
        rd_take && mode == EDC_NORMAL && syn == 0 |=>
        flags == 3'h0 && rd_data == $past(mem_data))
        else $error("clean read reported error");
    err_flag_a: assert property (
        rd_take && mode == EDC_NORMAL && syn != 0 |=> any_error_flag)
        else $error("error not flagged");
    check_err_a: assert property (rd_take && mode == EDC_NORMAL &&
        $countones(syn) == 1 |=> flags == 3'h6 && rd_data == $past(mem_data))
        else $error("check bit error misreported");
    comp_read_a: assert property (
        rd_take && mode == EDC_COMP_READ && in_syn == 0 |=>
        flags == 3'h0 && rd_data == ~$past(mem_data))
        else $error("complement read wrong");
    fix_data_a: assert property (
        rd_take && col_hit |=> flags == 3'h7 && rd_data == $past(exp_fix))
        else $error("single data error not corrected");
    reset_clear_a: assert property (disable iff (1'b0) reset |=>
        !wr_valid && !rd_valid && flags == 3'h0)
        else $error("outputs not cleared by reset");

    cover property (rd_valid && flags == 3'h7);
    cover property (rd_valid && flags == 3'h4);
    cover property (rd_take && mode == EDC_COMP_READ);
    cover property (write_req && mode == EDC_COMP_WRITE);
endmodule : edc_asserts

// *** sim/testbench.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module testbench
    import edc_pkg::*;
;
    localparam logic [DATA_W-1:0] D = 16'hA5C3;
    logic               mclk = 1'b0, reset = 1'b1, parity_check_en = 1'b1;
    logic               cpu_write = 1'b0, cpu_read = 1'b0;
    logic [DATA_W-1:0]  cpu_wdata = '0, arr_data, cpu_rdata, arr_wdata, got;
    logic [DATA_W-1:0]  mem_d = '0, soft_d = '0, hard_m = '0, hard_v = '0;
    logic [CHECK_W-1:0] mem_c = '0, soft_c = '0, arr_check, arr_wcheck;
    logic               cpu_rvalid, cpu_busy, uncorrectable, arr_we;
    logic [2:0]         flags;
    int                 n_errors = 0;
    int                 n_tests = 0;

    always #12.5 mclk = ~mclk;
    edc_if bus ();
    edc_slice #(.WIDTH(DATA_W)) i_edc_slice (.mclk(mclk), .reset(reset),
        .parity_check_en(parity_check_en), .bus(bus));
    edc_host i_edc_host (.mclk(mclk), .reset(reset), .cpu_write(cpu_write),
        .cpu_read(cpu_read), .cpu_wdata(cpu_wdata), .arr_data(arr_data),
        .arr_check(arr_check), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
        .cpu_busy(cpu_busy), .uncorrectable(uncorrectable), .arr_we(arr_we),
        .arr_wdata(arr_wdata), .arr_wcheck(arr_wcheck), .bus(bus));
    edc_asserts i_edc_asserts (.mclk(mclk), .reset(reset),
        .write_req(bus.write_req), .read_req(bus.read_req), .mode(bus.mode),
        .sys_data(bus.sys_data), .mem_data(bus.mem_data),
        .mem_check(bus.mem_check), .wr_data(bus.wr_data),
        .wr_check(bus.wr_check), .wr_valid(bus.wr_valid),
        .rd_data(bus.rd_data), .rd_parity(bus.rd_parity),
        .rd_valid(bus.rd_valid), .any_error_flag(bus.any_error_flag),
        .error_type_flag_high(bus.error_type_flag_high),
        .error_type_flag_low(bus.error_type_flag_low));

    assign flags = {bus.any_error_flag, bus.error_type_flag_high,
                    bus.error_type_flag_low};
    // array word: soft flips vanish on rewrite, stuck bits never do
    assign arr_data  = ((mem_d ^ soft_d) & ~hard_m) | (hard_v & hard_m);
    assign arr_check = mem_c ^ soft_c;
    always @(posedge mclk) begin
        if (arr_we === 1'b1) begin
            mem_d  <= arr_wdata;
            mem_c  <= arr_wcheck;
            soft_d <= '0;
            soft_c <= '0;
        end
    end

    function automatic logic [CHECK_W-1:0] gen(logic [DATA_W-1:0] d);
        logic [CHECK_W-1:0] c;
        for (int i = 0; i < CHECK_W; i++) c[i] = ^(d & MATRIX[i]);
        return c;
    endfunction : gen

    task automatic wait_idle();
        int n = 0;
        @(posedge mclk) #1;
        while (cpu_busy !== 1'b0 && n < 40) begin
            @(posedge mclk) #1;
            n++;
        end
        `CHK(cpu_busy, 1'b0)
    endtask : wait_idle

    task automatic cpu_wr(input logic [DATA_W-1:0] d);
        @(posedge mclk);
        cpu_write <= 1'b1;
        cpu_wdata <= d;
        @(posedge mclk);
        cpu_write <= 1'b0;
        #1;
        `CHK(arr_we, 1'b1)
        `CHK({arr_wdata, arr_wcheck}, {d, gen(d)})
        `CHK(bus.parity_error, 1'b0)
        wait_idle();
    endtask : cpu_wr

    task automatic cpu_rd(output logic [DATA_W-1:0] d);
        int n = 0;
        @(posedge mclk);
        cpu_read <= 1'b1;
        @(posedge mclk);
        cpu_read <= 1'b0;
        @(posedge mclk) #1;
        while (cpu_rvalid !== 1'b1 && n < 20) begin
            @(posedge mclk) #1;
            n++;
        end
        `CHK(cpu_rvalid, 1'b1)
        d = cpu_rdata;
        wait_idle();
    endtask : cpu_rd

    task automatic print_verdict();
        $display("counts: %0d mismatches in %0d compares", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        #1;
        `CHK({flags, bus.wr_valid, bus.rd_valid}, 5'h00)
        for (int k = 0; k < 4; k++) cpu_wr(16'hFFFF >> (k * 5));
        cpu_wr(D);
        cpu_rd(got);
        `CHK({got, flags}, {D, EDC_FLAG_NONE})
        $display("test clean done");
        for (int i = 0; i < DATA_W; i++) begin
            @(posedge mclk) soft_d <= 16'h0001 << i;
            cpu_rd(got);
            `CHK({got, flags}, {D, EDC_FLAG_DATA})
            `CHK(mem_d, D)
        end
        $display("test data errors done");
        for (int i = 0; i < CHECK_W; i++) begin
            @(posedge mclk) soft_c <= 6'h01 << i;
            cpu_rd(got);
            `CHK({got, flags}, {D, EDC_FLAG_CHECK})
            `CHK(mem_c, gen(D))
        end
        $display("test check errors done");
        @(posedge mclk);
        hard_m <= 16'h8000;
        hard_v <= ~D & 16'h8000;
        soft_d <= 16'h4000;
        cpu_rd(got);
        `CHK({got, flags}, {D, EDC_FLAG_DATA})
        `CHK(uncorrectable, 1'b0)
        $display("test hard plus soft done");
        @(posedge mclk) hard_m <= '0;
        cpu_wr(D);
        @(posedge mclk) soft_d <= 16'h0003;
        cpu_rd(got);
        `CHK({flags, uncorrectable}, {EDC_FLAG_DOUBLE, 1'b1})
        $display("test double soft done");
        @(posedge mclk) reset <= 1'b1;
        @(posedge mclk) reset <= 1'b0;
        #1;
        `CHK({flags, cpu_rdata}, 19'h00000)
        $display("test reset done");
        print_verdict();
    end
endmodule : testbench
